// ### src/dsr_port_logic.sv
// pin-facing logic of a burst-of-two sram with separate ddr read and write ports
// assumes all pins, including both clock pairs, are asynchronous to clk_sys
// Notes on behaviour
// - write select low at positive input clock rise starts a write
// - write select high deselects the write port and ignores write data
// - byte lane selects sampled on both input clock rises; unselected lanes unchanged
// - lane 0 bits 8:0, lane 1 17:9, lane 2 26:18, lane 3 35:27
// - read address on positive input rise, write address on negative input rise
// - address 23, 22 or 21 bits by width; selects a word pair
// - address ignored on the edge of a deselected port
// - read data launched on output clock rises, input clocks in single-clock mode
// - read data outputs float while the read port is deselected
// - read select low at positive input clock rise starts a read
// - deselected read finishes its burst, then floats after next positive output rise
// - every read delivers exactly two sequential words
// - every access starts on a positive input clock rise
// - inputs captured on both input clock rises; single-clock mode launches there too
// - free-running echo clocks follow the clock pair that launches read data
// - write data sampled on both input clock rises during writes
// - pll disabled gives one-cycle read latency, limited to 167 MHz
`timescale 1ns/1ns

module dsr_port_logic #(
    parameter int DATA_W = dsr_pkg::DATA_W,
    parameter int ADDR_W = dsr_pkg::ADDR_W,
    parameter int LANES = dsr_pkg::LANES
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic kClk,
    input wire logic kClkN,
    input wire logic outClk,
    input wire logic outClkN,
    input wire logic singleClock,
    input wire logic pllDisableN,
    input wire logic writePortSelectN,
    input wire logic readPortSelectN,
    input wire logic [LANES-1:0] byteLaneWriteSelectN,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] writeData,
    output logic [DATA_W-1:0] readData,
    output logic readDataEn,
    output logic echoTiming,
    output logic echoTimingN
);

    localparam int CTRL_W = 8;

    // expand active-low lane selects into a bit mask, nine bits per lane
    function automatic logic [DATA_W-1:0] laneMask(input logic [LANES-1:0] selN);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++)
        begin
            m[i*dsr_pkg::LANE_W +: dsr_pkg::LANE_W] = {dsr_pkg::LANE_W{~selN[i]}};
        end
        return m;
    endfunction

    // two-stage synchronisers; stage one is read by stage two only
    logic [CTRL_W-1:0] ctrlMeta;
    logic [CTRL_W-1:0] ctrlSync;
    logic [LANES-1:0] laneMeta;
    logic [LANES-1:0] laneSync;
    logic [ADDR_W-1:0] addrMeta;
    logic [ADDR_W-1:0] addrSync;
    logic [DATA_W-1:0] dataMeta;
    logic [DATA_W-1:0] dataSync;
    logic [3:0] clkLast;

    always_ff @(posedge clk_sys)
    begin
        ctrlMeta <= {kClk, kClkN, outClk, outClkN, singleClock, pllDisableN,
                     writePortSelectN, readPortSelectN};
        ctrlSync <= ctrlMeta;
        laneMeta <= byteLaneWriteSelectN;
        laneSync <= laneMeta;
        addrMeta <= address;
        addrSync <= addrMeta;
        dataMeta <= writeData;
        dataSync <= dataMeta;
    end

    logic kS;
    logic kNS;
    logic cS;
    logic cNS;
    logic singleS;
    logic pllOn;
    logic wpsS;
    logic rpsS;

    assign {kS, kNS, cS, cNS, singleS, pllOn, wpsS, rpsS} = ctrlSync;

    // data and clocks pass equal stages, so sampled data lines up with the edge seen
    // tracks through reset too: idle-high negative pins give no false edge on release
    always_ff @(posedge clk_sys)
    begin
        clkLast <= {kS, kNS, cS, cNS};
    end

    logic kRise;
    logic kNRise;
    logic outPos;
    logic outNeg;
    logic outPosLvl;
    logic outNegLvl;

    assign kRise = kS & ~clkLast[3];
    assign kNRise = kNS & ~clkLast[2];
    // single-clock mode moves launch and echo timing onto the input pair
    assign outPos = singleS ? kRise : (cS & ~clkLast[1]);
    assign outNeg = singleS ? kNRise : (cNS & ~clkLast[0]);
    assign outPosLvl = singleS ? kS : cS;
    assign outNegLvl = singleS ? kNS : cNS;

    // write port
    logic wrArmed;
    logic [DATA_W-1:0] wrWord0;
    logic [DATA_W-1:0] wrMask0;
    logic [DATA_W-1:0] wrWord1;
    logic [DATA_W-1:0] wrMask1;
    logic [ADDR_W-1:0] wrAddr;
    logic memWe;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wrArmed <= 1'b0;
            memWe <= 1'b0;
            wrWord0 <= '0;
            wrMask0 <= '0;
            wrWord1 <= '0;
            wrMask1 <= '0;
            wrAddr <= '0;
        end
        else
        begin
            memWe <= 1'b0;
            if (kRise)
            begin
                wrArmed <= ~wpsS;
                if (!wpsS)
                begin
                    wrWord0 <= dataSync;
                    wrMask0 <= laneMask(laneSync);
                end
            end
            else if (kNRise && wrArmed)
            begin
                // address and data of a deselected port are never taken
                wrArmed <= 1'b0;
                wrAddr <= addrSync;
                wrWord1 <= dataSync;
                wrMask1 <= laneMask(laneSync);
                memWe <= 1'b1;
            end
        end
    end

    // read request pipeline: one stage with the pll off, two with it on
    logic reqV;
    logic [ADDR_W-1:0] reqAddr;
    logic stgV;
    logic [ADDR_W-1:0] stgAddr;
    logic launchV;
    logic [ADDR_W-1:0] launchAddr;

    assign launchV = pllOn ? stgV : reqV;
    assign launchAddr = pllOn ? stgAddr : reqAddr;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reqV <= 1'b0;
            reqAddr <= '0;
            stgV <= 1'b0;
            stgAddr <= '0;
        end
        else
        begin
            if (outPos)
            begin
                stgV <= pllOn & reqV;
                stgAddr <= reqAddr;
            end
            // in single-clock mode both events share an edge; the new request waits
            if (kRise)
            begin
                reqV <= ~rpsS;
                if (!rpsS)
                begin
                    reqAddr <= addrSync;
                end
            end
            else if (outPos)
            begin
                reqV <= 1'b0;
            end
        end
    end

    logic [DATA_W-1:0] rdWord0;
    logic [DATA_W-1:0] rdWord1;

    dsr_word_pair_array #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_array (
        .clk_sys(clk_sys),
        .writeEn(memWe),
        .writeAddr(wrAddr),
        .writeWord0(wrWord0),
        .writeWord1(wrWord1),
        .writeMask0(wrMask0),
        .writeMask1(wrMask1),
        .readAddr(launchAddr),
        .readWord0(rdWord0),
        .readWord1(rdWord1)
    );

    // read output burst
    dsr_pkg::dsr_rd_e rdState;
    logic [DATA_W-1:0] word1Hold;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdState <= dsr_pkg::RD_IDLE;
            readData <= '0;
            readDataEn <= 1'b0;
            word1Hold <= '0;
        end
        else if (outPos)
        begin
            if (launchV)
            begin
                readData <= rdWord0;
                word1Hold <= rdWord1;
                readDataEn <= 1'b1;
                rdState <= dsr_pkg::RD_FIRST;
            end
            else
            begin
                // last burst done; float after this positive output rise
                readDataEn <= 1'b0;
                rdState <= dsr_pkg::RD_IDLE;
            end
        end
        else if (outNeg && rdState == dsr_pkg::RD_FIRST)
        begin
            readData <= word1Hold;
            rdState <= dsr_pkg::RD_SECOND;
        end
    end

    // echo clocks run whether or not a read is under way
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            echoTiming <= dsr_pkg::RST_LEVEL;
            echoTimingN <= dsr_pkg::RST_LEVEL;
        end
        else
        begin
            echoTiming <= outPosLvl;
            echoTimingN <= outNegLvl;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence wrHead;
        kRise && !wpsS;
    endsequence

    sequence rdLaunch;
        outPos && launchV;
    endsequence

    wr_start_arm_a: assert property (wrHead |=> wrArmed)
        else $error("write select low did not arm a write");

    wr_desel_a: assert property ((kRise && wpsS) |=> !wrArmed && !memWe)
        else $error("deselected write port still armed");

    wr_lane_mask_a: assert property (memWe |-> wrMask1 == laneMask($past(laneSync)))
        else $error("second word lane mask does not match lane selects");

    wr_addr_edge_a: assert property (memWe |-> $past(kNRise) && wrAddr == $past(addrSync))
        else $error("write address not taken on negative input rise");

    wr_two_words_a: assert property (memWe |-> !wrArmed && $past(wrArmed))
        else $error("write committed without a first word");

    rd_word0_a: assert property (rdLaunch |=> readDataEn && readData == $past(rdWord0))
        else $error("first read word not launched on positive output rise");

    rd_word1_a: assert property ((outNeg && !outPos && rdState == dsr_pkg::RD_FIRST)
        |=> readData == $past(word1Hold) && rdState == dsr_pkg::RD_SECOND)
        else $error("second read word missing");

    rd_float_a: assert property ((outPos && !launchV) |=> !readDataEn ##1 1)
        else $error("read outputs not floated after burst");

    rd_idle_off_a: assert property ((rdState == dsr_pkg::RD_IDLE) |-> !readDataEn)
        else $error("read outputs driven while idle");

    rd_req_take_a: assert property ((kRise && !rpsS) |=> reqV && reqAddr == $past(addrSync))
        else $error("read request not taken");

    echo_follow_a: assert property (##1 1 |-> echoTiming == $past(outPosLvl))
        else $error("echo clock does not follow launch clock");

endmodule

// ### src/dsr_pkg.sv
// constants shared by the burst-of-two sram port logic and its word-pair array
// assumes every pin is sampled by clk_sys at several times the link clock rate
package dsr_pkg;

    localparam int DATA_W = 36;
    localparam int ADDR_W = 21;
    localparam int LANE_W = 9;
    localparam int LANES = DATA_W / LANE_W;

    localparam int SYS_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_CYCLES = LINK_PERIOD_NS / SYS_PERIOD_NS;

    localparam int PLL_OFF_MAX_MHZ = 167;

    localparam logic RST_SELECT_N = 1'b1;
    localparam logic RST_LEVEL = 1'b0;
    localparam logic [1:0] ONE_DELAY = 2'h1;
    localparam logic [1:0] TWO_DELAY = 2'h2;

    typedef enum logic [1:0]
    {
        RD_IDLE = 2'h0,
        RD_FIRST = 2'h1,
        RD_SECOND = 2'h3
    } dsr_rd_e;

endpackage

// ### src/dsr_word_pair_array.sv
// two storage banks sharing one address, one word of each burst per bank
// assumes write commands arrive already masked and pulsed on clk_sys
`timescale 1ns/1ns

module dsr_word_pair_array #(
    parameter int DATA_W = dsr_pkg::DATA_W,
    parameter int ADDR_W = dsr_pkg::ADDR_W
) (
    input wire logic clk_sys,
    input wire logic writeEn,
    input wire logic [ADDR_W-1:0] writeAddr,
    input wire logic [DATA_W-1:0] writeWord0,
    input wire logic [DATA_W-1:0] writeWord1,
    input wire logic [DATA_W-1:0] writeMask0,
    input wire logic [DATA_W-1:0] writeMask1,
    input wire logic [ADDR_W-1:0] readAddr,
    output logic [DATA_W-1:0] readWord0,
    output logic [DATA_W-1:0] readWord1
);

    logic [DATA_W-1:0] bank0 [0:(2**ADDR_W)-1];
    logic [DATA_W-1:0] bank1 [0:(2**ADDR_W)-1];

    // unselected lanes keep their stored bits
    always_ff @(posedge clk_sys)
    begin
        if (writeEn)
        begin
            bank0[writeAddr] <= (bank0[writeAddr] & ~writeMask0) | (writeWord0 & writeMask0);
            bank1[writeAddr] <= (bank1[writeAddr] & ~writeMask1) | (writeWord1 & writeMask1);
        end
    end

    assign readWord0 = bank0[readAddr];
    assign readWord1 = bank1[readAddr];

endmodule

// ### sim/dsr_ctrl_model.sv
// controller-side clock source: input and output clock pairs of the sram
// assumes the bench drives selects, address and data from clk_sys
`timescale 1ns/1ns
module dsr_ctrl_model #(
    parameter int HALF_NS = 160,
    parameter int SKEW_NS = 100
) (
    input wire logic run,
    output logic kClk,
    output logic kClkN,
    output logic outClk,
    output logic outClkN
);
    // clocks stand still until run; phase kept off the clk_sys grid
    initial
    begin
        kClk = 1'b0;
        wait (run === 1'b1);
        #7;
        forever
        begin
            kClk = ~kClk;
            #HALF_NS;
        end
    end
    // output pair lags as board flight time would; one process drives it
    initial
    begin
        outClk = 1'b0;
        wait (run === 1'b1);
        #(7 + SKEW_NS);
        forever
        begin
            outClk = ~outClk;
            #HALF_NS;
        end
    end
    assign kClkN = ~kClk;
    assign outClkN = ~outClk;
endmodule

// ### sim/ddr_dual_port_sram_interface_bench.sv
// bench for the burst-of-two sram port logic
// assumes a 320 ns link clock from the controller model
`timescale 1ns/1ns
module ddr_dual_port_sram_interface_bench;
    localparam int AW = 6;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic run = 1'b0;
    logic singleClock = 1'b0;
    logic pllDisableN = 1'b0;
    logic writePortSelectN = 1'b1;
    logic readPortSelectN = 1'b1;
    logic [3:0] byteLaneWriteSelectN = 4'hf;
    logic [AW-1:0] address = 6'h0;
    logic [35:0] writeData = 36'h0;
    logic kClk, kClkN, outClk, outClkN, readDataEn, echoTiming, echoTimingN;
    logic [35:0] readData, w0, w1;
    logic [35:0] m0 [64];
    logic [35:0] m1 [64];
    logic enPrev = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int enCyc = 0;
    int kCyc = 0;
    int lat0, lat;

    always #20 clk_sys = ~clk_sys;

    dsr_ctrl_model dsr_ctrl_model_i (.run(run), .kClk(kClk), .kClkN(kClkN),
        .outClk(outClk), .outClkN(outClkN));
    // short address keeps the word-pair arrays small
    dsr_port_logic #(.ADDR_W(AW)) dsr_port_logic_i (.clk_sys(clk_sys), .srst(srst),
        .kClk(kClk), .kClkN(kClkN), .outClk(outClk), .outClkN(outClkN),
        .singleClock(singleClock), .pllDisableN(pllDisableN),
        .writePortSelectN(writePortSelectN), .readPortSelectN(readPortSelectN),
        .byteLaneWriteSelectN(byteLaneWriteSelectN), .address(address),
        .writeData(writeData), .readData(readData), .readDataEn(readDataEn),
        .echoTiming(echoTiming), .echoTimingN(echoTimingN));

    // word0 lands with the enable, word1 half a link period later
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        enPrev <= readDataEn;
        if (readDataEn === 1'b1 && enPrev !== 1'b1)
        begin
            enCyc <= cyc;
            w0 <= readData;
        end
        if (cyc == enCyc + 4)
            w1 <= readData;
    end

    task finish_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic pin(input int w);
        pin = (w == 0) ? kClk : (w == 1) ? kClkN : outClk;
    endfunction

    // bounded wait for a raw clock pin rise, seen at clk_sys
    task rise(input int w);
        logic p;
        int i;
        p = pin(w);
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pin(w) && !p)
                break;
            p = pin(w);
        end
        if (i == 20)
        begin
            n_fail++;
            $display("Error at %0t: link clock edge timed out", $time);
            finish_test;
        end
    endtask

    task till(input int c);
        int i;
        for (i = 0; i < 60 && cyc < c; i++)
            @(posedge clk_sys);
        if (i == 60)
        begin
            n_fail++;
            $display("Error at %0t: cycle wait timed out", $time);
            finish_test;
        end
    endtask

    // one link period; pins change mid-way between edges for margin
    task beat(input logic wN, input logic rN, input logic [AW-1:0] aK,
        input logic [AW-1:0] aN, input logic [35:0] d0, input logic [35:0] d1,
        input logic [3:0] l0, input logic [3:0] l1);
        writePortSelectN <= wN;
        readPortSelectN <= rN;
        address <= aK;
        writeData <= d0;
        byteLaneWriteSelectN <= l0;
        rise(0);
        kCyc = cyc;
        repeat (2) @(posedge clk_sys);
        writePortSelectN <= 1'b1;
        readPortSelectN <= 1'b1;
        address <= aN;
        writeData <= d1;
        byteLaneWriteSelectN <= l1;
        rise(1);
        repeat (2) @(posedge clk_sys);
    endtask

    task idle;
        beat(1'b1, 1'b1, 6'h0, 6'h0, 36'h0, 36'h0, 4'hf, 4'hf);
    endtask

    function logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
        input logic [3:0] l);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (!l[i])
                merge[9*i +: 9] = nw[9*i +: 9];
    endfunction

    // read address on the k phase is junk, it must be ignored
    task wr(input logic [AW-1:0] a, input logic [35:0] d0, input logic [35:0] d1,
        input logic [3:0] l0, input logic [3:0] l1);
        beat(1'b0, 1'b1, ~a, a, d0, d1, l0, l1);
        m0[a] = merge(m0[a], d0, l0);
        m1[a] = merge(m1[a], d1, l1);
    endtask

    task rd(input logic [AW-1:0] a, output int lt);
        beat(1'b1, 1'b0, a, ~a, 36'hfffffffff, 36'hfffffffff, 4'h0, 4'h0);
        till(kCyc + 20);
        lt = enCyc - kCyc;
        till(enCyc + 6);
        chk(w0, m0[a]);
        chk(w1, m1[a]);
        till(enCyc + 12);
        chk({35'h0, readDataEn}, 36'h0);
    endtask

    task echo_chk(input int w);
        rise(w);
        repeat (4) @(posedge clk_sys);
        chk({34'h0, echoTiming, echoTimingN}, 36'h2);
    endtask

    task s_basic;
        wr(6'h5, 36'h123456789, 36'habcdef012, 4'h0, 4'h0);
        rd(6'h5, lat0);
        $display("basic write and read done");
    endtask

    // lane selects differ between the two halves, then read straight after
    task s_lanes;
        wr(6'h5, 36'hfffffffff, 36'h000000000, 4'h5, 4'ha);
        wr(6'h9, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        rd(6'h5, lat);
        rd(6'h9, lat);
        $display("lane select test done");
    endtask

    task s_deselect;
        beat(1'b1, 1'b1, 6'h5, 6'h5, 36'h0, 36'h0, 4'h0, 4'h0);
        rd(6'h5, lat);
        $display("deselect test done");
    endtask

    task s_pll;
        pllDisableN <= 1'b1;
        idle;
        rd(6'h9, lat);
        chk(36'(lat - lat0), 36'h8);
        pllDisableN <= 1'b0;
        idle;
        $display("pll latency test done");
    endtask

    task s_single;
        echo_chk(2);
        singleClock <= 1'b1;
        idle;
        echo_chk(0);
        rd(6'h5, lat);
        singleClock <= 1'b0;
        idle;
        $display("single clock test done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        run <= 1'b1;
        rise(1);
        repeat (2) @(posedge clk_sys);
        s_basic;
        s_lanes;
        s_deselect;
        s_pll;
        s_single;
        finish_test;
    end
endmodule
